/* File: src/wwt_consts.svh */
// Behaviour
// - Count is 16 bits, a low 8-bit stage carrying into a high stage.
// - Count rate is clock divided by 2, or by 128 when rate select is set.
// - A service access in idle, or in run outside the enabled window, loads the high byte with reload, clears the low byte.
// - After service, counting resumes upward from reload times 256.
// - Overflow before service raises the watchdog interrupt and starts prewarning.
// - Prewarning lasts 30 hex counts, then the system reset output asserts.
// - Service inside the enabled window starts prewarning without interrupt, reset follows.
// - Forbidden window spans 0000 hex up to boundary byte followed by 00.
// - Service to overflow takes 2^(1+6*select)*(65536-reload*256) clocks.
// - With window on and boundary above reload, boundary sets the service period.
// - In debug mode the count is suspended by default and holds.
`ifndef WWT_CONSTS_SVH
`define WWT_CONSTS_SVH

`define WWT_ADDR_W        8
`define WWT_OFS_CTRL      8'h00
`define WWT_OFS_RELOAD    8'h04
`define WWT_OFS_WINDOW    8'h08
`define WWT_OFS_SERVICE   8'h0C
`define WWT_OFS_STATUS    8'h10
`define WWT_OFS_COUNT     8'h14

`define WWT_CTRL_ENABLE   0
`define WWT_CTRL_RATE     1
`define WWT_CTRL_WINDOW   2
`define WWT_CTRL_DBGSUSP  3
`define WWT_CTRL_RESET    4'h8

`define WWT_STAT_NMI      0
`define WWT_STAT_PREWARN  1
`define WWT_STAT_RESET    2
`define WWT_STAT_VIOL     3

`define WWT_DIV_FAST      2
`define WWT_DIV_SLOW      128
`define WWT_PREWARN_COUNT 16'h0030
`define WWT_COUNT_MAX     16'hFFFF

`endif

/* File: src/wwt_counter.sv */
`timescale 1ns/1ps

module wwt_counter (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        inc,
   input  wire logic        load,
   input  wire logic        clear,
   input  wire logic [7:0]  load_high,
   output logic      [15:0] count
);
   import wwt_pkg::*;

   wwt_cnt_state_t s;
   wwt_cnt_state_t next_s;

   always_comb begin
      next_s = s;
      if (clear) begin
         next_s = '0;
      end else if (load) begin
         next_s.high = load_high;
         next_s.low = 8'h00;
      end else if (inc) begin
         next_s.low = s.low + 8'h01;
         if (s.low == 8'hFF) begin
            next_s.high = s.high + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign count = {s.high, s.low};

endmodule

/* File: src/wwt_pkg.sv */
package wwt_pkg;

   typedef enum logic [1:0] {
      WWT_IDLE,
      WWT_RUN,
      WWT_PREWARN,
      WWT_RESET
   } wwt_mode_t;

   typedef struct packed {
      logic [6:0] cnt;
      logic       tick;
   } wwt_presc_state_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } wwt_cnt_state_t;

   typedef struct packed {
      wwt_mode_t   mode;
      logic        enable;
      logic        rate_select_bit;
      logic        window_en;
      logic        dbg_suspend;
      logic [7:0]  reload_high_byte;
      logic [7:0]  window_boundary_byte;
      logic        nmi;
      logic        rst_out;
      logic        viol;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } wwt_top_state_t;

endpackage

/* File: src/wwt_prescaler.sv */
`timescale 1ns/1ps
`include "wwt_consts.svh"

module wwt_prescaler #(
   parameter int DIV_FAST = `WWT_DIV_FAST,
   parameter int DIV_SLOW = `WWT_DIV_SLOW
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic slow,
   input  wire logic clear,
   input  wire logic hold,
   output logic      tick
);
   import wwt_pkg::*;

   initial begin
      if (DIV_FAST < 1 || DIV_SLOW < 1 || DIV_FAST > 128 || DIV_SLOW > 128) begin
         $error("wwt_prescaler: divider out of range 1..128");
      end
   end

   wwt_presc_state_t s;
   wwt_presc_state_t next_s;
   logic [6:0]       last;

   always_comb begin
      last = slow ? 7'(DIV_SLOW - 1) : 7'(DIV_FAST - 1);
      next_s = s;
      next_s.tick = 1'b0;
      if (clear) begin
         next_s.cnt = 7'h00;
      end else if (!hold) begin
         if (s.cnt >= last) begin
            next_s.cnt = 7'h00;
            next_s.tick = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule

/* File: src/wwt_top.sv */
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "wwt_consts.svh"

module wwt_top #(
   parameter int DIV_FAST = `WWT_DIV_FAST,
   parameter int DIV_SLOW = `WWT_DIV_SLOW
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`WWT_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   debug_mode,
   output logic                        watchdog_nmi_request,
   output logic                        watchdog_system_reset_out
);
   import wwt_pkg::*;

   initial begin
      if (`WWT_ADDR_W < 5) begin
         $error("wwt_top: address too narrow for the register map");
      end
      // The prescaler counter is seven bits wide, so no divider above 128 fits.
      if (DIV_FAST < 1 || DIV_FAST > 128) begin
         $error("wwt_top: fast divider out of range 1..128");
      end
      if (DIV_SLOW < 1 || DIV_SLOW > 128) begin
         $error("wwt_top: slow divider out of range 1..128");
      end
      if (`WWT_PREWARN_COUNT == 16'h0000) begin
         $error("wwt_top: prewarning length must not be zero");
      end
   end

   wwt_top_state_t s;
   wwt_top_state_t next_s;

   logic [15:0] watchdog_counter;
   logic        tick;
   logic        cnt_inc;
   logic        cnt_load;
   logic        cnt_clear;
   logic        presc_clear;
   logic        presc_hold;
   logic        suspended;
   logic        setup_done;
   logic        commit;
   logic        wr;
   logic        service;
   logic        overflow;
   logic        in_window;
   logic [31:0] rdata;
   logic        mapped;
   logic        wr_ctrl;
   logic        wr_reload;
   logic        wr_window;
   logic        wr_status;
   logic        prewarn_done;

   function automatic logic [31:0] zext8(input logic [7:0] v);
      return {24'h000000, v};
   endfunction

   function automatic logic addr_is(input logic [`WWT_ADDR_W-1:0] a,
                                    input logic [`WWT_ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   // Unused control bits read as zero so software can mask nothing.
   function automatic logic [31:0] ctrl_word(input wwt_top_state_t st);
      logic [31:0] w;
      w = 32'h00000000;
      w[`WWT_CTRL_ENABLE] = st.enable;
      w[`WWT_CTRL_RATE] = st.rate_select_bit;
      w[`WWT_CTRL_WINDOW] = st.window_en;
      w[`WWT_CTRL_DBGSUSP] = st.dbg_suspend;
      return w;
   endfunction

   function automatic logic [31:0] status_word(input wwt_top_state_t st);
      logic [31:0] w;
      w = 32'h00000000;
      w[`WWT_STAT_NMI] = st.nmi;
      w[`WWT_STAT_PREWARN] = (st.mode == WWT_PREWARN);
      w[`WWT_STAT_RESET] = st.rst_out;
      w[`WWT_STAT_VIOL] = st.viol;
      return w;
   endfunction

   wwt_prescaler #(
      .DIV_FAST (DIV_FAST),
      .DIV_SLOW (DIV_SLOW)
   ) wwt_prescaler_inst (
      .clk     (clk),
      .reset_n (reset_n),
      .slow    (s.rate_select_bit),
      .clear   (presc_clear),
      .hold    (presc_hold),
      .tick    (tick)
   );

   wwt_counter wwt_counter_inst (
      .clk       (clk),
      .reset_n   (reset_n),
      .inc       (cnt_inc),
      .load      (cnt_load),
      .clear     (cnt_clear),
      .load_high (s.reload_high_byte),
      .count     (watchdog_counter)
   );

   // Read mux for the access phase; data is registered in the same cycle as pready.
   always_comb begin
      rdata = 32'h00000000;
      mapped = 1'b1;
      if (addr_is(paddr, `WWT_OFS_CTRL)) begin
         rdata = ctrl_word(s);
      end else if (addr_is(paddr, `WWT_OFS_RELOAD)) begin
         rdata = zext8(s.reload_high_byte);
      end else if (addr_is(paddr, `WWT_OFS_WINDOW)) begin
         rdata = zext8(s.window_boundary_byte);
      end else if (addr_is(paddr, `WWT_OFS_SERVICE)) begin
         rdata = 32'h00000000;
      end else if (addr_is(paddr, `WWT_OFS_STATUS)) begin
         rdata = status_word(s);
      end else if (addr_is(paddr, `WWT_OFS_COUNT)) begin
         rdata = {16'h0000, watchdog_counter};
      end else begin
         mapped = 1'b0;
      end
   end

   always_comb begin
      next_s = s;
      setup_done = psel && penable && !s.pready;
      commit = psel && penable && s.pready;
      wr = commit && pwrite;
      service = wr && addr_is(paddr, `WWT_OFS_SERVICE);
      wr_ctrl = wr && addr_is(paddr, `WWT_OFS_CTRL);
      wr_reload = wr && addr_is(paddr, `WWT_OFS_RELOAD);
      wr_window = wr && addr_is(paddr, `WWT_OFS_WINDOW);
      wr_status = wr && addr_is(paddr, `WWT_OFS_STATUS);
      suspended = debug_mode && s.dbg_suspend;
      presc_hold = suspended || (s.mode == WWT_IDLE) || (s.mode == WWT_RESET);
      presc_clear = 1'b0;
      cnt_inc = 1'b0;
      cnt_load = 1'b0;
      cnt_clear = 1'b0;
      overflow = tick && !suspended && (watchdog_counter == `WWT_COUNT_MAX);
      // inclusive forbidden window
      // A boundary above the reload delays the earliest legal service, which is what
      // shortens the usable service period; no separate period logic is needed.
      in_window = watchdog_counter <= {s.window_boundary_byte, 8'h00};
      prewarn_done = (watchdog_counter == `WWT_PREWARN_COUNT);

      // Bus slave: one wait state, answer registered.
      next_s.pready = setup_done;
      if (setup_done) begin
         next_s.prdata = pwrite ? 32'h00000000 : rdata;
         next_s.pslverr = !mapped;
      end else begin
         next_s.prdata = 32'h00000000;
         next_s.pslverr = 1'b0;
      end

      if (wr_ctrl) begin
         next_s.enable = pwdata[`WWT_CTRL_ENABLE];
         next_s.rate_select_bit = pwdata[`WWT_CTRL_RATE];
         next_s.window_en = pwdata[`WWT_CTRL_WINDOW];
         next_s.dbg_suspend = pwdata[`WWT_CTRL_DBGSUSP];
      end
      if (wr_reload) begin
         next_s.reload_high_byte = pwdata[7:0];
      end
      if (wr_window) begin
         next_s.window_boundary_byte = pwdata[7:0];
      end
      // Write one to clear; a same-cycle event below sets again and wins.
      if (wr_status) begin
         if (pwdata[`WWT_STAT_NMI]) begin
            next_s.nmi = 1'b0;
         end
         if (pwdata[`WWT_STAT_VIOL]) begin
            next_s.viol = 1'b0;
         end
      end

      case (s.mode)
         WWT_IDLE: begin
            if (service) begin
               cnt_load = 1'b1;
               presc_clear = 1'b1;
            end
            if (wr_ctrl && pwdata[`WWT_CTRL_ENABLE]) begin
               next_s.mode = WWT_RUN;
            end
         end
         WWT_RUN: begin
            if (service) begin
               if (s.window_en && in_window) begin
                  next_s.viol = 1'b1;
                  next_s.mode = WWT_PREWARN;
                  cnt_clear = 1'b1;
                  presc_clear = 1'b1;
               end else begin
                  cnt_load = 1'b1;
                  presc_clear = 1'b1;
               end
            end else if (overflow) begin
               next_s.nmi = 1'b1;
               next_s.mode = WWT_PREWARN;
               cnt_inc = 1'b1;
            end else begin
               cnt_inc = tick && !suspended;
               if (wr_ctrl && !pwdata[`WWT_CTRL_ENABLE]) begin
                  next_s.mode = WWT_IDLE;
               end
            end
         end
         WWT_PREWARN: begin
            if (prewarn_done) begin
               next_s.rst_out = 1'b1;
               next_s.mode = WWT_RESET;
            end else begin
               cnt_inc = tick && !suspended;
            end
         end
         WWT_RESET: begin
            next_s.rst_out = 1'b1;
         end
         default: begin
            next_s.mode = WWT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
         s.mode <= WWT_IDLE;
         s.dbg_suspend <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign watchdog_nmi_request = s.nmi;
   assign watchdog_system_reset_out = s.rst_out;

endmodule

/* File: test/windowed_watchdog_timer_tb.sv */
`timescale 1ns/1ps
`include "wwt_consts.svh"
module windowed_watchdog_timer_tb;
   logic clk = 1'b0, reset_n = 1'b0, go = 1'b0, wr = 1'b0, debug_mode = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, done, err, nmi, rst;
   logic [7:0]  addr = 8'h00, paddr;
   logic [31:0] wdata = 32'h0, pwdata, prdata, rdata, a;
   int failures = 0, cmp_count = 0, cycles = 0, n;
   localparam int SLOW_DIV = 4;
   always #5 clk = ~clk;
   wwt_top #(.DIV_SLOW(SLOW_DIV)) wwt_top_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .debug_mode(debug_mode),
      .watchdog_nmi_request(nmi), .watchdog_system_reset_out(rst));
   wwt_cpu_model wwt_cpu_model_inst (.clk(clk), .go(go), .wr(wr), .addr(addr),
      .wdata(wdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rdata(rdata),
      .err(err), .done(done));
   task final_report;
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report;
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task check_rng(input int v, input int lo, input int hi);
      cmp_count++;
      if (v < lo || v > hi) begin
         failures++;
         $display("[FAIL] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      addr <= ad;
      wdata <= d;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (done !== 1'b1) @(negedge clk);
   endtask
   task rd_chk(input logic [7:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      check(rdata, exp);
   endtask
   task wait_out(input bit which);
      n = 0;
      while ((which ? rst : nmi) !== 1'b1) begin
         @(negedge clk);
         n++;
      end
   endtask
   task reset_dut;
      @(posedge clk);
      reset_n <= 1'b0;
      debug_mode <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
   endtask
   task t_reset_map;
      rd_chk(8'h00, 32'h8);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h10, 32'h0);
      rd_chk(8'h14, 32'h0);
      rd_chk(8'h18, 32'h0);
      check(err, 1'b1);
   endtask
   // Servicing early keeps the part alive; here it is left to expire on purpose.
   // A boundary over the count must not matter while the window is off.
   task t_overflow(input logic [31:0] ctrl, input int div);
      apb(1'b1, 8'h04, 32'hFF);
      apb(1'b1, 8'h08, 32'hFF);
      apb(1'b1, 8'h00, ctrl);
      apb(1'b1, 8'h0C, 32'h0);
      wait_out(1'b0);
      check_rng(n, div * (65536 - 255 * 256) - 3, div * (65536 - 255 * 256) + 3);
      wait_out(1'b1);
      check_rng(n, div * `WWT_PREWARN_COUNT - 3, div * `WWT_PREWARN_COUNT + 3);
      apb(1'b1, 8'h10, 32'h1);
      check(nmi, 1'b0);
      check(rst, 1'b1);
      rd_chk(8'h10, 32'h4);
      reset_dut;
      @(negedge clk);
      check({nmi, rst}, 2'b00);
   endtask
   task t_window;
      apb(1'b1, 8'h08, 32'h01);
      apb(1'b1, 8'h0C, 32'h0);
      apb(1'b1, 8'h00, 32'h5);
      repeat (540) @(posedge clk);
      apb(1'b1, 8'h0C, 32'h0);
      rd_chk(8'h10, 32'h0);
      apb(1'b1, 8'h0C, 32'h0);
      rd_chk(8'h10, 32'hA);
      wait_out(1'b1);
      check_rng(n, 80, 100);
      check(nmi, 1'b0);
      reset_dut;
   endtask
   task t_debug;
      apb(1'b1, 8'h00, 32'h9);
      apb(1'b1, 8'h0C, 32'h0);
      @(posedge clk);
      debug_mode <= 1'b1;
      apb(1'b0, 8'h14, 32'h0);
      a = rdata;
      repeat (40) @(posedge clk);
      rd_chk(8'h14, a);
      @(posedge clk);
      debug_mode <= 1'b0;
      repeat (40) @(posedge clk);
      apb(1'b0, 8'h14, 32'h0);
      check_rng(int'(rdata) - int'(a), 18, 30);
      reset_dut;
   endtask
   initial begin
      reset_dut;
      t_reset_map;
      t_overflow(32'h1, `WWT_DIV_FAST);
      t_overflow(32'h3, SLOW_DIV);
      t_window;
      t_debug;
      final_report;
   end
endmodule

/* File: test/wwt_cpu_model.sv */
`timescale 1ns/1ps
module wwt_cpu_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic        wr,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite = 1'b0,
   output logic [7:0]       paddr = 8'h00,
   output logic [31:0]      pwdata = 32'h0,
   output logic [31:0]      rdata,
   output logic             err,
   output logic             done = 1'b0
);
   always @(posedge clk) begin
      done <= 1'b0;
      if (!psel && go) begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= addr;
         pwdata <= wdata;
      end else if (psel && !penable) begin
         penable <= 1'b1;
      end else if (psel && pready) begin
         psel <= 1'b0;
         penable <= 1'b0;
         // Released lines flip so a slave cannot lean on stale values.
         paddr <= ~paddr;
         pwdata <= ~pwdata;
         rdata <= prdata;
         err <= pslverr;
         done <= 1'b1;
      end
   end
endmodule

/* File: test/wwt_top_properties.sv */
`timescale 1ns/1ps
`include "wwt_consts.svh"
module wwt_top_properties #(
   parameter int DIV_FAST = `WWT_DIV_FAST,
   parameter int DIV_SLOW = `WWT_DIV_SLOW
) (
   input wire logic                   clk,
   input wire logic                   reset_n,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [`WWT_ADDR_W-1:0] paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   debug_mode,
   input wire logic                   watchdog_nmi_request,
   input wire logic                   watchdog_system_reset_out
);
   logic nmi_clr;
   assign nmi_clr = psel && penable && pready && pwrite && paddr == `WWT_OFS_STATUS
                    && pwdata[`WWT_STAT_NMI];
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_reset_clears: assert property (@(posedge clk) disable iff (1'b0)
      !reset_n |=> !watchdog_nmi_request && !watchdog_system_reset_out && !pready)
      else $error("outputs not cleared by reset");
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not two cycles");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_reset_held: assert property (watchdog_system_reset_out |=> watchdog_system_reset_out)
      else $error("reset output dropped");
   a_nmi_held: assert property (watchdog_nmi_request && !nmi_clr |=> watchdog_nmi_request)
      else $error("nmi dropped without clear");
   a_prewarn_gap: assert property ($rose(watchdog_nmi_request) |->
      !watchdog_system_reset_out [*8]) else $error("reset without prewarning");
   a_no_late_nmi: assert property (watchdog_system_reset_out |=>
      !$rose(watchdog_nmi_request)) else $error("nmi after reset output");
endmodule
bind wwt_top wwt_top_properties #(.DIV_FAST(DIV_FAST), .DIV_SLOW(DIV_SLOW))
   wwt_top_properties_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .debug_mode(debug_mode), .watchdog_nmi_request(watchdog_nmi_request),
   .watchdog_system_reset_out(watchdog_system_reset_out));
